// ===== hw/sis_core.sv
// Purpose: Stack pointer and interrupt entry/return sequencing
// Assumes: Core runs straight off ref_clk_in, no division
// Notes: Instruction decode outside supplies one-cycle op strobes
// Operation
// - Push byte lowers stack pointer by one
// - Call or interrupt entry lowers pointer by two
// - Pop byte raises stack pointer by one
// - Return instructions raise stack pointer by two
// - Pointer is two I/O bytes, reset zero
// - Core clock is undivided chip clock
// - Register ALU operation completes in one cycle
// - Take interrupt only if both enables set
// - Vectors sit at lowest program addresses
// - Lowest vector index wins priority
// - Entry clears global enable, exit sets it
// - Vectoring or writing one clears flag
// - Flag set while disabled is remembered
// - Level sources request only while present
// - One instruction runs after exit first
// - Flags register never saved or restored
// - Global mask takes effect same cycle
// - Instruction after unmask runs before interrupt
// - Entry takes four cycles, pushes PC
// - Wake from sleep adds four cycles
// - Exit takes four cycles, pops PC
`timescale 1ns/10ps
module sis_core
    import sis_pkg::*;
#(
    parameter int N_SRC = 8,
    parameter logic [N_SRC-1:0] SRC_HAS_FLAG = '1,
    parameter int PC_W = 12
)
(
    input wire logic ref_clk_in,
    input wire logic rst_in,
    input wire logic [2:0] op_in,
    input wire logic insn_done_in,
    input wire logic set_gie_in,
    input wire logic clr_gie_in,
    input wire logic sleeping_in,
    input wire logic [PC_W-1:0] pc_in,
    input wire logic [N_SRC-1:0] cond_in,
    input wire logic [N_SRC-1:0] enable_in,
    input wire logic [N_SRC-1:0] flag_clear_in,
    input wire logic io_wr_in,
    input wire logic [5:0] io_addr_in,
    input wire logic [7:0] io_wdata_in,
    input wire logic [7:0] alu_a_in,
    input wire logic [7:0] alu_b_in,
    input wire logic alu_sub_in,
    input wire logic [7:0] mem_rdata_in,
    output logic [7:0] io_rdata_out,
    output logic [15:0] sp_out,
    output logic gie_out,
    output logic mem_we_out,
    output logic mem_re_out,
    output logic [15:0] mem_addr_out,
    output logic [7:0] mem_wdata_out,
    output logic pc_load_out,
    output logic [PC_W-1:0] pc_next_out,
    output logic stall_out,
    output logic [N_SRC-1:0] pending_out,
    output logic [7:0] alu_result_out
);
    localparam logic [1:0] ENTRY_LAST = 2'(SIS_ENTRY_CYCLES - 1);
    localparam logic [1:0] EXIT_LAST = 2'(SIS_EXIT_CYCLES - 1);
    localparam logic [1:0] WAKE_LAST = 2'(SIS_WAKE_CYCLES - 1);

    logic [7:0] sp_lo_reg;
    logic [7:0] sp_hi_reg;
    logic gie_reg;
    sis_state_t state_reg;
    logic [1:0] cnt_reg;
    logic [PC_W-1:0] save_pc_reg;
    logic [PC_W-1:0] ret_pc_reg;
    logic [PC_W-1:0] vec_reg;
    logic [N_SRC-1:0] served_reg;
    logic hold_reg;
    logic [N_SRC-1:0] req;
    logic [N_SRC-1:0] armed;
    logic any_armed;
    logic [$clog2(N_SRC+1)-1:0] win_idx;
    logic take;
    logic [15:0] sp;
    logic [15:0] sp_next;

    assign sp = {sp_hi_reg, sp_lo_reg};

    genvar g;
    generate
        for (g = 0; g < N_SRC; g++)
        begin : g_src
            sis_irq_source #(
                .HAS_FLAG(SRC_HAS_FLAG[g])
            ) u_src (
                .ref_clk_in(ref_clk_in),
                .rst_in(rst_in),
                .cond_in(cond_in[g]),
                .sw_clear_in(flag_clear_in[g]),
                .served_in(served_reg[g]),
                .req_out(req[g])
            );
        end
    endgenerate

    // Both enables needed; a mask in this cycle blocks at once
    assign armed = req & enable_in & {N_SRC{gie_reg && !clr_gie_in}};
    assign any_armed = |armed;

    // Lowest index is the lowest vector, so it wins
    always_comb
    begin
        win_idx = '0;
        for (int i = N_SRC - 1; i >= 0; i--)
            if (armed[i])
                win_idx = ($clog2(N_SRC+1))'(i);
    end

    // Hold_reg blocks entry for one instruction after unmask or exit
    assign take = any_armed && insn_done_in && !hold_reg
        && state_reg == SIS_RUN;

    always_comb
    begin
        sp_next = sp;
        unique case (op_in)
            SIS_OP_PUSH: sp_next = sp - 16'h0001;
            SIS_OP_POP: sp_next = sp + 16'h0001;
            SIS_OP_CALL: sp_next = sp - 16'h0002;
            SIS_OP_RET: sp_next = sp + 16'h0002;
            default: sp_next = sp;
        endcase
    end

    // Stack pointer bytes; core adjustments override same-cycle writes
    always_ff @(posedge ref_clk_in)
    begin
        if (rst_in)
        begin
            sp_lo_reg <= SIS_SP_RESET;
            sp_hi_reg <= SIS_SP_RESET;
        end
        else if (state_reg == SIS_ENTRY && cnt_reg < 2'd2)
        begin
            {sp_hi_reg, sp_lo_reg} <= sp - 16'h0001;
        end
        else if (state_reg == SIS_EXIT && cnt_reg < 2'd2)
        begin
            {sp_hi_reg, sp_lo_reg} <= sp + 16'h0001;
        end
        else if (op_in != SIS_OP_NONE && op_in != SIS_OP_IRET)
        begin
            {sp_hi_reg, sp_lo_reg} <= sp_next;
        end
        else if (io_wr_in)
        begin
            if (io_addr_in == SIS_IO_SP_LOW)
                sp_lo_reg <= io_wdata_in;
            if (io_addr_in == SIS_IO_SP_HIGH)
                sp_hi_reg <= io_wdata_in;
        end
    end

    always_ff @(posedge ref_clk_in)
    begin
        if (rst_in)
            io_rdata_out <= 8'h00;
        else if (io_addr_in == SIS_IO_SP_LOW)
            io_rdata_out <= sp_lo_reg;
        else if (io_addr_in == SIS_IO_SP_HIGH)
            io_rdata_out <= sp_hi_reg;
        else
            io_rdata_out <= 8'h00;
    end

    // Only the enable bit is touched; other status flags are left alone
    always_ff @(posedge ref_clk_in)
    begin
        if (rst_in)
            gie_reg <= 1'b0;
        else if (take || clr_gie_in)
            gie_reg <= 1'b0;
        else if (set_gie_in)
            gie_reg <= 1'b1;
        else if (state_reg == SIS_EXIT && cnt_reg == EXIT_LAST)
            gie_reg <= 1'b1;
    end

    always_ff @(posedge ref_clk_in)
    begin
        if (rst_in)
            hold_reg <= 1'b0;
        else if (set_gie_in && !gie_reg)
            hold_reg <= 1'b1;
        else if (state_reg == SIS_EXIT && cnt_reg == EXIT_LAST)
            hold_reg <= 1'b1;
        else if (insn_done_in)
            hold_reg <= 1'b0;
    end

    // Entry, wake and exit sequencing
    always_ff @(posedge ref_clk_in)
    begin
        if (rst_in)
        begin
            state_reg <= SIS_RUN;
            cnt_reg <= 2'd0;
            save_pc_reg <= '0;
            vec_reg <= SIS_RESET_VECTOR;
            served_reg <= '0;
        end
        else
        begin
            served_reg <= '0;
            unique case (state_reg)
                SIS_RUN:
                begin
                    cnt_reg <= 2'd0;
                    if (take)
                    begin
                        save_pc_reg <= pc_in;
                        vec_reg <= PC_W'(SIS_RESET_VECTOR)
                            + PC_W'((win_idx + 1) * SIS_VEC_STEP);
                        served_reg <= armed & (~armed + 1'b1);
                        state_reg <= sleeping_in ? SIS_WAKE : SIS_ENTRY;
                    end
                    else if (op_in == SIS_OP_IRET)
                        state_reg <= SIS_EXIT;
                end
                SIS_WAKE:
                begin
                    cnt_reg <= cnt_reg + 2'd1;
                    if (cnt_reg == WAKE_LAST)
                    begin
                        cnt_reg <= 2'd0;
                        state_reg <= SIS_ENTRY;
                    end
                end
                SIS_ENTRY:
                begin
                    cnt_reg <= cnt_reg + 2'd1;
                    if (cnt_reg == ENTRY_LAST)
                        state_reg <= SIS_GUARD;
                end
                SIS_EXIT:
                begin
                    cnt_reg <= cnt_reg + 2'd1;
                    if (cnt_reg == EXIT_LAST)
                        state_reg <= SIS_GUARD;
                end
                SIS_GUARD:
                begin
                    cnt_reg <= 2'd0;
                    state_reg <= SIS_RUN;
                end
                default: state_reg <= SIS_RUN;
            endcase
        end
    end

    // Return address gathered high byte first from the pop cycles
    always_ff @(posedge ref_clk_in)
    begin
        if (rst_in)
            ret_pc_reg <= '0;
        else if (state_reg == SIS_EXIT && cnt_reg == 2'd1)
            ret_pc_reg <= PC_W'({mem_rdata_in, 8'h00});
        else if (state_reg == SIS_EXIT && cnt_reg == 2'd2)
            ret_pc_reg <= ret_pc_reg | PC_W'(mem_rdata_in);
    end

    // Memory port: entry pushes low then high byte, exit pops high then low
    always_ff @(posedge ref_clk_in)
    begin
        if (rst_in)
        begin
            mem_we_out <= 1'b0;
            mem_re_out <= 1'b0;
            mem_addr_out <= 16'h0000;
            mem_wdata_out <= 8'h00;
        end
        else
        begin
            mem_we_out <= state_reg == SIS_ENTRY && cnt_reg < 2'd2;
            mem_re_out <= state_reg == SIS_EXIT && cnt_reg < 2'd2;
            mem_addr_out <= (state_reg == SIS_EXIT) ? sp + 16'h0001 : sp;
            mem_wdata_out <= (cnt_reg == 2'd0) ? 8'(save_pc_reg)
                : 8'(save_pc_reg >> 8);
        end
    end

    always_ff @(posedge ref_clk_in)
    begin
        if (rst_in)
        begin
            pc_load_out <= 1'b0;
            pc_next_out <= '0;
            stall_out <= 1'b0;
        end
        else
        begin
            pc_load_out <= 1'b0;
            if (state_reg == SIS_ENTRY && cnt_reg == ENTRY_LAST)
            begin
                pc_load_out <= 1'b1;
                pc_next_out <= vec_reg;
            end
            else if (state_reg == SIS_EXIT && cnt_reg == EXIT_LAST)
            begin
                pc_load_out <= 1'b1;
                pc_next_out <= ret_pc_reg;
            end
            stall_out <= take || state_reg == SIS_WAKE
                || (state_reg == SIS_ENTRY && cnt_reg != ENTRY_LAST)
                || (state_reg == SIS_RUN && op_in == SIS_OP_IRET)
                || (state_reg == SIS_EXIT && cnt_reg != EXIT_LAST);
        end
    end

    // Single-cycle ALU result, registered as the destination write
    always_ff @(posedge ref_clk_in)
    begin
        if (rst_in)
            alu_result_out <= 8'h00;
        else
            alu_result_out <= alu_sub_in ? alu_a_in - alu_b_in
                : alu_a_in + alu_b_in;
    end

    always_ff @(posedge ref_clk_in)
    begin
        if (rst_in)
        begin
            sp_out <= 16'h0000;
            gie_out <= 1'b0;
            pending_out <= '0;
        end
        else
        begin
            sp_out <= sp;
            gie_out <= gie_reg;
            pending_out <= req;
        end
    end
endmodule : sis_core

// ===== hw/sis_pkg.sv
// Purpose: Shared constants for the stack and interrupt sequencer
// Assumes: Byte-addressed stack, one vector word per source
// Notes: I/O offsets are I/O-space addresses, not data addresses
package sis_pkg;
    localparam logic [5:0] SIS_IO_SP_LOW = 6'h3d;
    localparam logic [5:0] SIS_IO_SP_HIGH = 6'h3e;
    localparam logic [7:0] SIS_SP_RESET = 8'h00;
    localparam logic [15:0] SIS_STACK_MIN = 16'h0060;
    localparam int SIS_ENTRY_CYCLES = 4;
    localparam int SIS_WAKE_CYCLES = 4;
    localparam int SIS_EXIT_CYCLES = 4;
    localparam int SIS_VEC_STEP = 1;
    localparam logic [11:0] SIS_RESET_VECTOR = 12'h000;
    typedef enum logic [2:0] {
        SIS_RUN = 3'b000,
        SIS_WAKE = 3'b001,
        SIS_ENTRY = 3'b011,
        SIS_EXIT = 3'b010,
        SIS_GUARD = 3'b110
    } sis_state_t;
    typedef enum logic [2:0] {
        SIS_OP_NONE = 3'h0,
        SIS_OP_PUSH = 3'h1,
        SIS_OP_POP = 3'h2,
        SIS_OP_CALL = 3'h3,
        SIS_OP_RET = 3'h4,
        SIS_OP_IRET = 3'h5
    } sis_op_t;
endpackage : sis_pkg

// ===== hw/sis_irq_source.sv
// Purpose: One interrupt source: sticky flag or plain level request
// Assumes: Condition input is already on the core clock
// Notes: A set in the same cycle as any clear wins
`timescale 1ns/10ps
module sis_irq_source
    import sis_pkg::*;
#(
    parameter bit HAS_FLAG = 1'b1
)
(
    input wire logic ref_clk_in,
    input wire logic rst_in,
    input wire logic cond_in,
    input wire logic sw_clear_in,
    input wire logic served_in,
    output logic req_out
);
    logic flag_reg;

    always_ff @(posedge ref_clk_in)
    begin
        if (rst_in)
            flag_reg <= 1'b0;
        else if (cond_in)
            flag_reg <= 1'b1;
        else if (sw_clear_in || served_in)
            flag_reg <= 1'b0;
    end

    // Level sources request only while the condition stands
    assign req_out = HAS_FLAG ? flag_reg : cond_in;
endmodule : sis_irq_source

// ===== testbench/sis_stack_mem.sv
// Purpose: Stack memory model beside the sequencer
// Assumes: Only the low nine address bits decode
// Notes: Idle read data is inverted so a stale byte never matches
`timescale 1ns/10ps
module sis_stack_mem
(
    input wire logic ref_clk_in,
    input wire logic we_in,
    input wire logic re_in,
    input wire logic [15:0] addr_in,
    input wire logic [7:0] wdata_in,
    output logic [7:0] rdata_out
);
    logic [7:0] mem [0:511];
    logic [7:0] last_reg = 8'h00;
    always_ff @(posedge ref_clk_in)
    begin
        if (we_in)
        begin
            mem[addr_in[8:0]] <= wdata_in;
        end
        if (re_in)
        begin
            last_reg <= mem[addr_in[8:0]];
        end
    end

    // Read answers within the strobe cycle, where the sequencer samples
    assign rdata_out = re_in ? mem[addr_in[8:0]] : ~last_reg;
endmodule : sis_stack_mem

// ===== testbench/sis_core_asserts.sv
// Purpose: Port assertions for the sequencer
// Assumes: Op strobes never overlap entry or exit
// Notes: sp_out trails the pointer by one cycle
`timescale 1ns/10ps
module sis_core_asserts
    import sis_pkg::*;
(
    input wire logic ref_clk_in,
    input wire logic rst_in,
    input wire logic [2:0] op_in,
    input wire logic insn_done_in,
    input wire logic set_gie_in,
    input wire logic clr_gie_in,
    input wire logic sleeping_in,
    input wire logic [7:0] alu_a_in,
    input wire logic [7:0] alu_b_in,
    input wire logic alu_sub_in,
    input wire logic [15:0] sp_out,
    input wire logic gie_out,
    input wire logic mem_we_out,
    input wire logic mem_re_out,
    input wire logic pc_load_out,
    input wire logic [7:0] alu_result_out
);
    default clocking cb @(posedge ref_clk_in);
    endclocking
    default disable iff (rst_in);
    a_push_dec: assert property (
        op_in == SIS_OP_PUSH |-> ##2 sp_out == $past(sp_out) - 16'h0001)
        else $error("push did not lower pointer by one");
    a_call_dec: assert property (
        op_in == SIS_OP_CALL |-> ##2 sp_out == $past(sp_out) - 16'h0002)
        else $error("call did not lower pointer by two");
    a_pop_inc: assert property (
        op_in == SIS_OP_POP |-> ##2 sp_out == $past(sp_out) + 16'h0001)
        else $error("pop did not raise pointer by one");
    a_ret_inc: assert property (
        op_in == SIS_OP_RET |-> ##2 sp_out == $past(sp_out) + 16'h0002)
        else $error("return did not raise pointer by two");
    a_alu_single: assert property (
        !$past(rst_in) |-> alu_result_out == ($past(alu_sub_in)
        ? $past(alu_a_in) - $past(alu_b_in)
        : $past(alu_a_in) + $past(alu_b_in)))
        else $error("alu result wrong or late");
    a_mask_now: assert property (
        clr_gie_in && !set_gie_in |=> ##1 !gie_out)
        else $error("mask did not clear global enable");
    a_unmask_waits: assert property (
        (set_gie_in && !clr_gie_in) ##1
        (insn_done_in && !gie_out && !clr_gie_in) |=> ##1 gie_out)
        else $error("entry right after unmask");
    a_entry_push: assert property (
        $fell(gie_out) && !$past(clr_gie_in, 2) && !$past(rst_in, 2)
        && !$past(sleeping_in, 2) |-> mem_we_out)
        else $error("entry without stack write");
    a_wake_push: assert property (
        $fell(gie_out) && !$past(clr_gie_in, 2) && !$past(rst_in, 2)
        && $past(sleeping_in, 2) |-> !mem_we_out [*4] ##1 mem_we_out)
        else $error("wake entry not delayed by four cycles");
    a_entry_time: assert property (
        $fell(gie_out) && !$past(clr_gie_in, 2) && !$past(rst_in, 2)
        |-> !pc_load_out [*2] ##[1:7] pc_load_out)
        else $error("vector load timing wrong");
    a_exit_pop: assert property (
        op_in == SIS_OP_IRET |-> ##[1:3] mem_re_out)
        else $error("exit without stack read");
    a_exit_gie: assert property (
        op_in == SIS_OP_IRET |-> ##6 gie_out)
        else $error("exit did not set global enable");
endmodule : sis_core_asserts

bind sis_core sis_core_asserts u_chk (.ref_clk_in(ref_clk_in),
    .rst_in(rst_in), .op_in(op_in), .insn_done_in(insn_done_in),
    .set_gie_in(set_gie_in), .clr_gie_in(clr_gie_in),
    .sleeping_in(sleeping_in),
    .alu_a_in(alu_a_in), .alu_b_in(alu_b_in), .alu_sub_in(alu_sub_in),
    .sp_out(sp_out), .gie_out(gie_out), .mem_we_out(mem_we_out),
    .mem_re_out(mem_re_out), .pc_load_out(pc_load_out),
    .alu_result_out(alu_result_out));

// ===== testbench/sis_core_tb.sv
// Purpose: Directed bench for the sequencer
// Assumes: Source 7 is level type, the rest flagged
// Notes: Stack bytes are read back from the memory model
`timescale 1ns/10ps
module sis_core_tb
    import sis_pkg::*;
;
    logic ref_clk = 0, rst = 1, insn_done = 0, set_gie = 0, clr_gie = 0;
    logic sleeping = 0, io_wr = 0, sub = 0, gie, mem_we, mem_re;
    logic pc_load, stall;
    logic [2:0] op = 0;
    logic [5:0] io_addr = 0;
    logic [7:0] cond = 0, en = 0, fclr = 0, io_wdata = 0, a = 0, b = 0;
    logic [7:0] mem_rdata, io_rdata, mem_wdata, pending, alu_res;
    logic [11:0] pc = 12'h5a3, pc_next;
    logic [15:0] sp, mem_addr;
    int n_mismatch = 0, check_count = 0, lat, lat2, stalls = 0;
    always #5 ref_clk = ~ref_clk;
    sis_core #(.N_SRC(8), .SRC_HAS_FLAG(8'h7f), .PC_W(12)) dut (
        .ref_clk_in(ref_clk), .rst_in(rst), .op_in(op),
        .insn_done_in(insn_done), .set_gie_in(set_gie),
        .clr_gie_in(clr_gie), .sleeping_in(sleeping), .pc_in(pc),
        .cond_in(cond), .enable_in(en), .flag_clear_in(fclr),
        .io_wr_in(io_wr), .io_addr_in(io_addr), .io_wdata_in(io_wdata),
        .alu_a_in(a), .alu_b_in(b), .alu_sub_in(sub),
        .mem_rdata_in(mem_rdata), .io_rdata_out(io_rdata), .sp_out(sp),
        .gie_out(gie), .mem_we_out(mem_we), .mem_re_out(mem_re),
        .mem_addr_out(mem_addr), .mem_wdata_out(mem_wdata),
        .pc_load_out(pc_load), .pc_next_out(pc_next),
        .stall_out(stall), .pending_out(pending),
        .alu_result_out(alu_res));
    sis_stack_mem stk (.ref_clk_in(ref_clk), .we_in(mem_we),
        .re_in(mem_re), .addr_in(mem_addr), .wdata_in(mem_wdata),
        .rdata_out(mem_rdata));
    task automatic tick(input int n = 1);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask : tick
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        check_count++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("MISMATCH %0t got %h exp %h", $time, got, exp);
        end
    endtask : chk
    task automatic io_write(input logic [5:0] ad, input logic [7:0] d);
        io_addr = ad;
        io_wdata = d;
        io_wr = 1'b1;
        tick();
        io_wr = 1'b0;
        tick();
    endtask : io_write
    task automatic io_read(input logic [5:0] ad, input logic [7:0] exp);
        io_addr = ad;
        tick();
        chk(16'(io_rdata), 16'(exp));
    endtask : io_read
    task automatic do_op(input logic [2:0] o, input int n);
        op = o;
        tick(n);
        op = 3'h0;
        tick();
    endtask : do_op
    // Zero op means an instruction boundary; counts cycles to the next PC load
    task automatic run(input logic [2:0] o, output int n);
        insn_done = (o == 3'h0);
        op = o;
        tick();
        insn_done = 1'b0;
        op = 3'h0;
        n = 1;
        stalls = 0;
        while (pc_load !== 1'b1 && n < 30)
        begin
            if (stall === 1'b1)
                stalls++;
            tick();
            n++;
        end
        chk(16'(pc_load), 16'h0001);
    endtask : run
    task automatic no_take;
        insn_done = 1'b1;
        tick();
        insn_done = 1'b0;
        tick(2);
        chk(16'(gie), 16'h0001);
    endtask : no_take
    task automatic end_of_test;
        if (n_mismatch == 0 && check_count > 0)
        begin
            $display("Test passed");
        end
        else
        begin
            $display("Test failed");
        end
        $finish;
    endtask : end_of_test
    initial
    begin
        #20000;
        n_mismatch++;
        end_of_test();
    end
    initial
    begin
        tick(6);
        rst = 1'b0;
        chk(sp, 16'h0000);
        io_read(SIS_IO_SP_HIGH, 8'h00);
        io_write(SIS_IO_SP_HIGH, 8'h01);
        io_write(SIS_IO_SP_LOW, 8'h00);
        io_read(SIS_IO_SP_HIGH, 8'h01);
        io_read(6'h3f, 8'h00);
        do_op(SIS_OP_PUSH, 2);
        chk(sp, 16'h00fe);
        do_op(SIS_OP_POP, 1);
        chk(sp, 16'h00ff);
        do_op(SIS_OP_CALL, 1);
        chk(sp, 16'h00fd);
        do_op(SIS_OP_RET, 1);
        chk(sp, 16'h00ff);
        do_op(SIS_OP_POP, 1);
        a = 8'hf0;
        b = 8'h20;
        tick();
        chk(16'(alu_res), 16'h0010);
        sub = 1'b1;
        tick();
        chk(16'(alu_res), 16'h00d0);
        cond = 8'h84;
        tick();
        cond = 8'h00;
        tick(3);
        chk(16'(pending), 16'h0004);
        fclr = 8'h04;
        tick();
        fclr = 8'h00;
        tick(2);
        chk(16'(pending), 16'h0000);
        // Source 0 stays disabled but would win if enables were ignored
        en = 8'h16;
        cond = 8'h17;
        tick();
        cond = 8'h00;
        set_gie = 1'b1;
        tick();
        set_gie = 1'b0;
        no_take();
        run(3'h0, lat);
        chk(16'(pc_next), 16'h0002);
        chk(16'(lat), 16'(SIS_ENTRY_CYCLES + 1));
        chk(16'(stalls), 16'h0004);
        chk(16'(gie), 16'h0000);
        tick(2);
        chk(sp, 16'h00fe);
        chk(16'(stk.mem[9'h100]), 16'h00a3);
        chk(16'(stk.mem[9'h0ff]), 16'h0005);
        chk(16'(pending[1]), 16'h0000);
        run(SIS_OP_IRET, lat2);
        chk(16'(pc_next), 16'(pc));
        chk(16'(stalls), 16'h0004);
        tick(2);
        chk(sp, 16'h0100);
        no_take();
        sleeping = 1'b1;
        run(3'h0, lat2);
        sleeping = 1'b0;
        chk(16'(lat2), 16'(lat + 4));
        chk(16'(stalls), 16'h0008);
        chk(16'(pc_next), 16'h0003);
        tick(2);
        run(SIS_OP_IRET, lat2);
        chk(16'(pc_next), 16'(pc));
        chk(16'(stalls), 16'h0004);
        tick(2);
        no_take();
        clr_gie = 1'b1;
        insn_done = 1'b1;
        tick();
        clr_gie = 1'b0;
        insn_done = 1'b0;
        tick(6);
        chk(sp, 16'h0100);
        chk(16'(pending[4]), 16'h0001);
        end_of_test();
    end
endmodule : sis_core_tb
